// *** logic/bsd_battery_short_diag_config.sv ***
// Module: serial configuration store for short-to-battery diagnostics, eight channels
`timescale 1ns/1ps
// Function
// - Bits 30:24 code, bit 31 write flag; code 0000010 addresses channels 0-3.
// - Code 0000011 addresses channels 4-7 with identical field handling.
// - Threshold codes at 23:22,17:16,11:10,5:4 select 0.7/0.9/1.1/1.3 V.
// - Every threshold code resets to 11, the highest level.
// - Retry fields at 21:18,15:12,9:6,3:0, below each threshold code.
// - After a short, wait sixteen times retry field PWM periods before retest.
// - Every retry field resets to 1111, a 240 period wait.
// - Wait counter advances once per PWM period of the channel.
// - Answer has bit 31 zero, echoed code, current fields in place.
module bsd_battery_short_diag_config (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso_out,
    output logic spi_miso_oe,
    input wire logic [bsd_pkg::CHANNELS-1:0] pwm_period_tick,
    input wire logic [bsd_pkg::CHANNELS-1:0] short_event,
    output logic [bsd_pkg::THR_W*bsd_pkg::CHANNELS-1:0] battery_short_threshold,
    output logic [bsd_pkg::RETRY_W*bsd_pkg::CHANNELS-1:0] battery_short_retry_count,
    output logic [bsd_pkg::CHANNELS-1:0] retry_waiting,
    output logic [bsd_pkg::CHANNELS-1:0] retry_start
);
    import bsd_pkg::*;

    // -------------------------------------------------------------------
    // Field helpers
    // -------------------------------------------------------------------
    // Threshold code of message slot k
    function automatic logic [THR_W-1:0] thr_of(input logic [DATA_W-1:0] w, input int k);
        thr_of = w[THR_LSB_FIRST - FIELD_STRIDE*k +: THR_W];
    endfunction : thr_of

    // Retry field of message slot k
    function automatic logic [RETRY_W-1:0] retry_of(input logic [DATA_W-1:0] w,
        input int k);
        retry_of = w[RETRY_LSB_FIRST - FIELD_STRIDE*k +: RETRY_W];
    endfunction : retry_of

    // Answer word: flag clear, code echoed, data fields in their places
    function automatic logic [FRAME_BITS-1:0] answer_of(input logic [CODE_MSB-CODE_LSB:0] code,
        input logic [DATA_W-1:0] data);
        answer_of = {1'b0, code, data};
    endfunction : answer_of

    // -------------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------------
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_d;
    logic cs_n_s1;
    logic cs_n_s2;
    logic cs_n_d;
    logic mosi_s1;
    logic mosi_s2;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;

    // Clock pin: two stages, then one history stage for edges
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sclk_s1 <= 1'b0; // Idle low, no false edge after reset
            sclk_s2 <= 1'b0;
            sclk_d <= 1'b0;
        end else begin
            sclk_s1 <= spi_sclk;
            sclk_s2 <= sclk_s1;
            sclk_d <= sclk_s2;
        end
    end

    // Select pin: resets to the deselected level
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cs_n_s1 <= 1'b1;
            cs_n_s2 <= 1'b1;
            cs_n_d <= 1'b1;
        end else begin
            cs_n_s1 <= spi_cs_n;
            cs_n_s2 <= cs_n_s1;
            cs_n_d <= cs_n_s2;
        end
    end

    // Data pin: same delay as the clock so each bit lines up with its edge
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            mosi_s1 <= 1'b0;
            mosi_s2 <= 1'b0;
        end else begin
            mosi_s1 <= spi_mosi;
            mosi_s2 <= mosi_s1;
        end
    end

    // Edge detection on synchronised levels
    assign sclk_rise = sclk_s2 & ~sclk_d;
    assign sclk_fall = ~sclk_s2 & sclk_d;
    assign cs_fall = ~cs_n_s2 & cs_n_d;
    assign cs_rise = cs_n_s2 & ~cs_n_d;

    // -------------------------------------------------------------------
    // Frame sequencer
    // -------------------------------------------------------------------
    bsd_frame_e state;
    bsd_frame_e next_state;
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic [FRAME_BITS-1:0] rx_shift;
    logic [FRAME_BITS-1:0] tx_shift;
    logic [FRAME_BITS-1:0] resp_word;
    logic [DATA_W-1:0] cfg_low;
    logic [DATA_W-1:0] cfg_high;
    logic frame_ok;
    logic msg_wr;
    logic [CODE_MSB-CODE_LSB:0] msg_code;
    logic hit_low;
    logic hit_high;
    logic wr_commit;

    // Decoded fields of a completed frame
    assign frame_ok = (bit_cnt == FRAME_BITS_CNT);
    assign msg_wr = rx_shift[RW_POS];
    assign msg_code = rx_shift[CODE_MSB:CODE_LSB];
    assign hit_low = (msg_code == CODE_CFG_LOW);
    assign hit_high = (msg_code == CODE_CFG_HIGH);
    // Store only complete frames that carry the write flag
    assign wr_commit = (state == BSD_DONE) && frame_ok && msg_wr;

    // Next state of the frame sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            BSD_IDLE: begin
                if (cs_fall) begin
                    next_state = BSD_SHIFT;
                end
            end
            BSD_SHIFT: begin
                if (cs_rise) begin
                    next_state = BSD_DONE;
                end
            end
            BSD_DONE: begin
                next_state = BSD_IDLE;
            end
            default: begin
                next_state = BSD_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state <= BSD_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // -------------------------------------------------------------------
    // Receive shifter, MSB first on rising clock
    // -------------------------------------------------------------------
    // Bit counter, saturates one past a full frame so long frames fail
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            bit_cnt <= '0;
        end else if (state == BSD_IDLE && cs_fall) begin
            bit_cnt <= '0;
        end else if (state == BSD_SHIFT && sclk_rise) begin
            if (bit_cnt != FRAME_BITS_CNT + 6'h01) begin
                bit_cnt <= bit_cnt + 6'h01; // Saturates past 32
            end
        end
    end

    // Data shifter, most significant bit arrives first
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rx_shift <= '0;
        end else if (state == BSD_SHIFT && sclk_rise) begin
            rx_shift <= {rx_shift[FRAME_BITS-2:0], mosi_s2};
        end
    end

    // -------------------------------------------------------------------
    // Transmit shifter, changes on falling clock
    // -------------------------------------------------------------------
    // Load on select, shift on falling clock
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            tx_shift <= '0;
            spi_miso_out <= 1'b0;
        end else if (state == BSD_IDLE && cs_fall) begin
            tx_shift <= resp_word; // Answer to previous frame
            spi_miso_out <= resp_word[FRAME_BITS-1];
        end else if (state == BSD_SHIFT && sclk_fall) begin
            tx_shift <= {tx_shift[FRAME_BITS-2:0], 1'b0};
            spi_miso_out <= tx_shift[FRAME_BITS-2];
        end
    end

    // -------------------------------------------------------------------
    // Data line enable
    // -------------------------------------------------------------------
    // High from select detected to deselect detected
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            spi_miso_oe <= 1'b0;
        end else if (cs_rise) begin
            spi_miso_oe <= 1'b0; // Release shared data line
        end else if (state == BSD_IDLE && cs_fall) begin
            spi_miso_oe <= 1'b1;
        end
    end

    // -------------------------------------------------------------------
    // Configuration store
    // -------------------------------------------------------------------
    // Low group store, channels 0-3
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_low <= CFG_RESET;
        end else if (wr_commit && hit_low) begin
            cfg_low <= rx_shift[DATA_W-1:0];
        end
    end

    // High group store, channels 4-7
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_high <= CFG_RESET;
        end else if (wr_commit && hit_high) begin
            cfg_high <= rx_shift[DATA_W-1:0];
        end
    end

    // -------------------------------------------------------------------
    // Response word for the next frame
    // -------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            resp_word <= RESP_RESET;
        end else if (state == BSD_DONE) begin
            if (!frame_ok) begin
                resp_word <= RESP_RESET; // Broken frame answers zero
            end else if (hit_low) begin
                resp_word <= answer_of(msg_code, msg_wr ? rx_shift[DATA_W-1:0] : cfg_low);
            end else if (hit_high) begin
                resp_word <= answer_of(msg_code, msg_wr ? rx_shift[DATA_W-1:0] : cfg_high);
            end else begin
                resp_word <= RESP_RESET; // Other codes belong elsewhere
            end
        end
    end

    // -------------------------------------------------------------------
    // Per-channel outputs and retry timer bank
    // -------------------------------------------------------------------
    bsd_retry_if #(.CHANNELS(CHANNELS), .RETRY_W(RETRY_W)) retry_link ();

    // Spread stored words over channels, slot k of each message, from flops
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            battery_short_threshold <= {CHANNELS{THR_RESET}};
            battery_short_retry_count <= {CHANNELS{RETRY_RESET}};
        end else begin
            for (int k = 0; k < CH_PER_MSG; k++) begin
                battery_short_threshold[k*THR_W +: THR_W] <= thr_of(cfg_low, k);
                battery_short_threshold[(k+CH_PER_MSG)*THR_W +: THR_W] <=
                    thr_of(cfg_high, k);
                battery_short_retry_count[k*RETRY_W +: RETRY_W] <= retry_of(cfg_low, k);
                battery_short_retry_count[(k+CH_PER_MSG)*RETRY_W +: RETRY_W] <=
                    retry_of(cfg_high, k);
            end
        end
    end

    // Timer bank inputs
    assign retry_link.tick = pwm_period_tick;
    assign retry_link.short_event = short_event;
    assign retry_link.retry_field = battery_short_retry_count;

    bsd_retry_timer #(
        .CHANNELS(CHANNELS)
    ) u_retry_timer (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .rif(retry_link.timer)
    );

    // Timer results, both registered inside the bank
    assign retry_waiting = retry_link.waiting;
    assign retry_start = retry_link.retry_go;
endmodule : bsd_battery_short_diag_config

// *** logic/bsd_pkg.sv ***
// Package: constants shared by the battery short diagnostic configuration block
package bsd_pkg;
    // -------------------------------------------------------------------
    // Message layout
    // -------------------------------------------------------------------
    localparam int FRAME_BITS = 32;
    localparam int BIT_CNT_W = 6;
    localparam logic [BIT_CNT_W-1:0] FRAME_BITS_CNT = 6'h20;
    localparam int RW_POS = 31;
    localparam int CODE_MSB = 30;
    localparam int CODE_LSB = 24;
    localparam int DATA_W = 24;
    localparam logic [6:0] CODE_CFG_LOW = 7'h02;
    localparam logic [6:0] CODE_CFG_HIGH = 7'h03;
    localparam logic [7:0] REG_CFG_LOW_OFFSET = 8'h02;
    localparam logic [7:0] REG_CFG_HIGH_OFFSET = 8'h03;

    // -------------------------------------------------------------------
    // Per-channel field layout inside the 24-bit data part
    // -------------------------------------------------------------------
    localparam int CH_PER_MSG = 4;
    localparam int CHANNELS = 8;
    localparam int FIELD_STRIDE = 6;
    localparam int THR_LSB_FIRST = 22;
    localparam int RETRY_LSB_FIRST = 18;
    localparam int THR_W = 2;
    localparam int RETRY_W = 4;

    // -------------------------------------------------------------------
    // Reset values and retry scaling
    // -------------------------------------------------------------------
    localparam logic [THR_W-1:0] THR_RESET = 2'h3;
    localparam logic [RETRY_W-1:0] RETRY_RESET = 4'hF;
    localparam logic [DATA_W-1:0] CFG_RESET = 24'hFFFFFF;
    localparam int RETRY_SCALE_SHIFT = 4;
    localparam int RETRY_CNT_W = RETRY_W + RETRY_SCALE_SHIFT;
    localparam logic [31:0] RESP_RESET = 32'h00000000;

    // Frame sequencing, Gray coded along idle -> shift -> done
    typedef enum logic [1:0] {
        BSD_IDLE = 2'b00,
        BSD_SHIFT = 2'b01,
        BSD_DONE = 2'b11
    } bsd_frame_e;
endpackage : bsd_pkg

// *** logic/bsd_retry_if.sv ***
// Interface: link between the configuration core and the retry timer bank
`timescale 1ns/1ps
interface bsd_retry_if #(
    parameter int CHANNELS = 8,
    parameter int RETRY_W = 4
) ();
    logic [CHANNELS-1:0] tick;
    logic [CHANNELS-1:0] short_event;
    logic [RETRY_W*CHANNELS-1:0] retry_field;
    logic [CHANNELS-1:0] waiting;
    logic [CHANNELS-1:0] retry_go;

    modport ctrl (
        output tick,
        output short_event,
        output retry_field,
        input waiting,
        input retry_go
    );
    modport timer (
        input tick,
        input short_event,
        input retry_field,
        output waiting,
        output retry_go
    );
endinterface : bsd_retry_if

// *** logic/bsd_retry_timer.sv ***
// Module: per-channel retry wait counters counted in PWM periods
`timescale 1ns/1ps
module bsd_retry_timer #(
    parameter int CHANNELS = 8
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    bsd_retry_if.timer rif
);
    import bsd_pkg::*;

    logic [RETRY_CNT_W-1:0] wait_cnt [CHANNELS];

    // -------------------------------------------------------------------
    // Wait counters
    // -------------------------------------------------------------------
    // Load sixteen times the field, count down once per PWM period
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < CHANNELS; i++) begin
                wait_cnt[i] <= '0;
            end
            rif.waiting <= '0;
            rif.retry_go <= '0;
        end else begin
            for (int i = 0; i < CHANNELS; i++) begin
                rif.retry_go[i] <= 1'b0;
                if (rif.short_event[i]) begin
                    wait_cnt[i] <= {rif.retry_field[i*RETRY_W +: RETRY_W],
                        {RETRY_SCALE_SHIFT{1'b0}}};
                    rif.waiting[i] <= 1'b1;
                end else if (rif.waiting[i]) begin
                    if (wait_cnt[i] == '0) begin
                        rif.waiting[i] <= 1'b0; // Wait over, allow retest
                        rif.retry_go[i] <= 1'b1;
                    end else if (rif.tick[i]) begin
                        wait_cnt[i] <= wait_cnt[i] - 1'b1;
                    end
                end
            end
        end
    end
endmodule : bsd_retry_timer

// *** test/bsd_diag_props.sv ***
// Checker: port-level properties of the battery short configuration block
`timescale 1ns/1ps
module bsd_diag_props (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    input wire logic spi_miso_out,
    input wire logic spi_miso_oe,
    input wire logic [bsd_pkg::CHANNELS-1:0] pwm_period_tick,
    input wire logic [bsd_pkg::CHANNELS-1:0] short_event,
    input wire logic [bsd_pkg::THR_W*bsd_pkg::CHANNELS-1:0] battery_short_threshold,
    input wire logic [bsd_pkg::RETRY_W*bsd_pkg::CHANNELS-1:0] battery_short_retry_count,
    input wire logic [bsd_pkg::CHANNELS-1:0] retry_waiting,
    input wire logic [bsd_pkg::CHANNELS-1:0] retry_start
);
    import bsd_pkg::*;
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    a_reset_defaults: assert property (
        $fell(sys_rst) |-> &{battery_short_threshold, battery_short_retry_count})
        else $error("config not at reset defaults");
    a_cfg_frame_stable: assert property (
        (!spi_cs_n)[*6] |-> $stable(battery_short_threshold) && $stable(battery_short_retry_count))
        else $error("config changed inside a frame");
    a_oe_idle_off: assert property (
        spi_cs_n[*4] |-> !spi_miso_oe)
        else $error("miso driven while deselected");
    a_oe_frame_on: assert property (
        (!spi_cs_n)[*4] |-> spi_miso_oe)
        else $error("miso not driven in frame");
    a_miso_shift_low: assert property (
        spi_miso_oe && !spi_cs_n && $changed(spi_miso_out) |-> !spi_sclk)
        else $error("miso changed while sclk high");
    a_event_starts_wait: assert property (
        short_event != '0 |=> (retry_waiting & $past(short_event)) == $past(short_event))
        else $error("short event did not start wait");
    a_start_single: assert property (
        retry_start != '0 |=> (retry_start & $past(retry_start)) == '0)
        else $error("retry start longer than one cycle");
    a_wait_ends_start: assert property (
        $fell(retry_waiting[0]) |-> retry_start[0])
        else $error("wait ended without retry start");
    a_zero_retry_fast: assert property (
        short_event[1] && battery_short_retry_count[7:4] == 4'h0 |-> ##[1:3] retry_start[1])
        else $error("zero retry field did not end quickly");
    c_cfg_write: cover property ($changed(battery_short_threshold));
    c_retry_end: cover property (retry_start[0]);
    c_zero_retry: cover property (short_event[1] && battery_short_retry_count[7:4] == 4'h0);
endmodule : bsd_diag_props

bind bsd_battery_short_diag_config bsd_diag_props u_props (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso_out(spi_miso_out), .spi_miso_oe(spi_miso_oe), .pwm_period_tick(pwm_period_tick),
    .short_event(short_event), .battery_short_threshold(battery_short_threshold),
    .battery_short_retry_count(battery_short_retry_count), .retry_waiting(retry_waiting),
    .retry_start(retry_start));

// *** test/bsd_host_model.sv ***
// Host controller model: serial master, mode 0, MSB first
`timescale 1ns/1ps
module bsd_host_model (
    input wire logic clk_sys,
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_mosi,
    input wire logic spi_miso_out,
    input wire logic spi_miso_oe
);
    logic miso_last;
    logic miso_line;
    // Released line shows the inverse of its last driven value
    assign miso_line = spi_miso_oe ? spi_miso_out : ~miso_last;
    always @(posedge clk_sys) begin
        if (spi_miso_oe) begin
            miso_last <= spi_miso_out;
        end
    end
    // Idle: deselected, clock low
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // One 32 bit frame; sclk period 8 clocks (400 ns)
    task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
        @(negedge clk_sys) spi_cs_n = 1'b0;
        repeat (8) @(negedge clk_sys);
        for (int i = 31; i >= 0; i--) begin
            spi_mosi = tx[i];
            repeat (4) @(negedge clk_sys);
            spi_sclk = 1'b1;
            repeat (4) @(negedge clk_sys);
            rx[i] = miso_line;
            spi_sclk = 1'b0;
        end
        repeat (4) @(negedge clk_sys);
        spi_cs_n = 1'b1;
        repeat (8) @(negedge clk_sys);
    endtask : xfer
endmodule : bsd_host_model

// *** test/test_battery_short_diag_config.sv ***
// Testbench: configuration frames and retry wait of the diagnostic block
`timescale 1ns/1ps
module test_battery_short_diag_config;
    import bsd_pkg::*;
    localparam logic [23:0] D_LO = 24'h050AB5;
    localparam logic [23:0] D_HI = 24'h9C3E62;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic spi_sclk, spi_cs_n, spi_mosi, spi_miso_out, spi_miso_oe;
    logic [CHANNELS-1:0] pwm_period_tick = '0;
    logic [CHANNELS-1:0] short_event = '0;
    logic [THR_W*CHANNELS-1:0] battery_short_threshold;
    logic [RETRY_W*CHANNELS-1:0] battery_short_retry_count;
    logic [CHANNELS-1:0] retry_waiting, retry_start;
    logic [31:0] rx;
    int err_total = 0;
    int n_compared = 0;
    int cycles = 0;
    always #25 clk_sys = ~clk_sys;
    bsd_battery_short_diag_config dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
        .spi_miso_out(spi_miso_out), .spi_miso_oe(spi_miso_oe),
        .pwm_period_tick(pwm_period_tick), .short_event(short_event),
        .battery_short_threshold(battery_short_threshold),
        .battery_short_retry_count(battery_short_retry_count),
        .retry_waiting(retry_waiting), .retry_start(retry_start));
    bsd_host_model host (.clk_sys(clk_sys), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso_out(spi_miso_out), .spi_miso_oe(spi_miso_oe));
    // Compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Threshold of slot k at bits 23-6k:22-6k, retry just below
    function automatic logic [7:0] thr_of(input logic [23:0] d);
        for (int k = 0; k < 4; k++) thr_of[2*k +: 2] = d[22-6*k +: 2];
    endfunction : thr_of
    function automatic logic [15:0] ret_of(input logic [23:0] d);
        for (int k = 0; k < 4; k++) ret_of[4*k +: 4] = d[18-6*k +: 4];
    endfunction : ret_of
    // Reset values seen on outputs and in a read answer
    task automatic t_reset_read;
        host.xfer({1'b0, CODE_CFG_LOW, 24'h000000}, rx);
        check("first answer", rx, 32'h00000000);
        host.xfer({1'b0, CODE_CFG_HIGH, 24'h000000}, rx);
        check("read low", rx, {1'b0, CODE_CFG_LOW, 24'hFFFFFF});
        check("thr reset", 32'(battery_short_threshold), 32'h0000FFFF);
        check("retry reset", battery_short_retry_count, 32'hFFFFFFFF);
    endtask : t_reset_read
    // Writes to both groups, all four threshold codes
    task automatic t_write_groups;
        host.xfer({1'b1, CODE_CFG_LOW, D_LO}, rx);
        check("read high", rx, {1'b0, CODE_CFG_HIGH, 24'hFFFFFF});
        check("thr low", 32'(battery_short_threshold[7:0]), 32'(thr_of(D_LO)));
        check("retry low", 32'(battery_short_retry_count[15:0]), 32'(ret_of(D_LO)));
        host.xfer({1'b1, CODE_CFG_HIGH, D_HI}, rx);
        check("echo low", rx, {1'b0, CODE_CFG_LOW, D_LO});
        check("thr high", 32'(battery_short_threshold[15:8]), 32'(thr_of(D_HI)));
        check("retry high", 32'(battery_short_retry_count[31:16]), 32'(ret_of(D_HI)));
    endtask : t_write_groups
    // Reads carrying other data and a write to another code leave the store alone
    task automatic t_read_keeps;
        host.xfer({1'b0, CODE_CFG_HIGH, 24'h000000}, rx);
        check("echo high", rx, {1'b0, CODE_CFG_HIGH, D_HI});
        host.xfer({1'b0, CODE_CFG_LOW, 24'h123456}, rx);
        check("high kept", rx, {1'b0, CODE_CFG_HIGH, D_HI});
        host.xfer({1'b1, 7'h04, 24'h000000}, rx);
        check("low kept", rx, {1'b0, CODE_CFG_LOW, D_LO});
        host.xfer({1'b0, CODE_CFG_LOW, 24'h000000}, rx);
        check("other code", rx, 32'h00000000);
        check("thr kept", 32'(battery_short_threshold),
            {16'h0000, thr_of(D_HI), thr_of(D_LO)});
        check("retry kept", battery_short_retry_count, {ret_of(D_HI), ret_of(D_LO)});
    endtask : t_read_keeps
    // Channel 0 waits 16 ticks (field 1), channel 1 field 0 ends at once
    task automatic t_retry;
        logic seen;
        seen = 1'b0;
        @(negedge clk_sys) short_event = 8'h03;
        @(negedge clk_sys) short_event = 8'h00;
        repeat (4) @(negedge clk_sys) seen |= retry_start[1];
        check("zero field end", 32'(seen), 32'h00000001);
        repeat (15) begin
            @(negedge clk_sys) pwm_period_tick = 8'h01;
            @(negedge clk_sys) pwm_period_tick = 8'h00;
        end
        check("still waiting", 32'({retry_waiting[0], retry_start[0]}), 32'h00000002);
        @(negedge clk_sys) pwm_period_tick = 8'h01;
        @(negedge clk_sys) pwm_period_tick = 8'h00;
        seen = 1'b0;
        repeat (3) @(negedge clk_sys) seen |= retry_start[0];
        check("wait ended", 32'(seen), 32'h00000001);
    endtask : t_retry
    // Reset in mid-run restores defaults, stops a wait, clears the pending answer
    task automatic t_mid_reset;
        @(negedge clk_sys) short_event = 8'h01;
        @(negedge clk_sys) short_event = 8'h00;
        sys_rst = 1'b1;
        repeat (6) @(negedge clk_sys);
        sys_rst = 1'b0;
        check("rst wait", 32'(retry_waiting), 32'h00000000);
        check("rst thr", 32'(battery_short_threshold), 32'h0000FFFF);
        check("rst retry", battery_short_retry_count, 32'hFFFFFFFF);
        repeat (4) @(negedge clk_sys);
        host.xfer({1'b0, CODE_CFG_HIGH, 24'h000000}, rx);
        check("rst answer", rx, 32'h00000000);
    endtask : t_mid_reset
    // Closing report
    task automatic print_verdict;
        $display("Compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict
    // Hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            print_verdict();
        end
    end
    // Main sequence
    initial begin
        repeat (6) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        t_reset_read();
        t_write_groups();
        t_read_keeps();
        t_retry();
        t_mid_reset();
        print_verdict();
    end
endmodule : test_battery_short_diag_config
